// ==== include/tsi2c_pkg.sv ====
// Constants shared by both ends of the touch controller serial link.
// Assumes a 100 MHz system clock on both ends.
package tsi2c_pkg;
	// ==========================================
	// Device register map (5-bit pointer)
	localparam logic [4:0] REG_CTRL0 = 5'h00;
	localparam logic [4:0] REG_CTRL1 = 5'h01;
	localparam logic [4:0] REG_CTRL2 = 5'h02;
	localparam logic [4:0] REG_MASK = 5'h04;
	localparam logic [4:0] REG_STAT = 5'h05;
	localparam logic [4:0] REG_SRST = 5'h1f;
	localparam logic [7:0] RST_CTRL0 = 8'h00;
	localparam logic [7:0] RST_CTRL1 = 8'h20;
	localparam logic [7:0] RST_CTRL2 = 8'h00;
	localparam logic [7:0] RST_MASK = 8'hc0;
	localparam int CTRL1_CONDIRQ_BIT = 5;
	localparam int STAT_PEND_BIT = 0;
	localparam int STAT_PEN_BIT = 2;
	// ==========================================
	// Command byte encodings
	localparam logic [2:0] CMD_WRITE = 3'h0;
	localparam logic [2:0] CMD_READ = 3'h2;
	localparam int CMD_HOST_BIT = 7;
	// ==========================================
	// Channel words
	localparam int N_CHANNEL_TAG = 5;
	localparam logic [2:0] CH_NONE = 3'h5;
	localparam logic [15:0] INVALID_WORD = 16'hffff;
	// Upper six address bits; value is arbitrary
	localparam logic [5:0] DEV_ADDR_HI = 6'h24;
	// ==========================================
	// Host controller registers of its own
	localparam logic [1:0] HREG_CTRL = 2'h0;
	localparam logic [1:0] HREG_TX = 2'h1;
	localparam logic [1:0] HREG_RX = 2'h2;
	localparam logic [1:0] HREG_STAT = 2'h3;
	localparam int HC_START = 0;
	localparam int HC_XFER = 1;
	localparam int HC_STOP = 2;
	localparam int HC_READ = 3;
	localparam int HC_NACK = 4;
	localparam int HS_BUSY = 0;
	localparam int HS_NACK = 1;
	localparam int HS_IRQ = 2;
	// ==========================================
	// Timing
	localparam int CLK_NS = 10;
	localparam int SCL_PERIOD_NS = 2500;
	localparam logic [7:0] QTR_CYC = 8'((SCL_PERIOD_NS / 4) / CLK_NS);
	typedef logic [15:0] tsi2c_word_t;
endpackage

// ==== include/tsi2c_if.sv ====
// Open-drain two-wire link plus active-low interrupt line.
// Each party drives enables only; the wire levels are resolved here.
`timescale 1ns/100ps
interface tsi2c_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_scl_out;
	logic s_scl_oe;
	logic s_sda_out;
	logic s_sda_oe;
	logic interrupt_out_n;
	logic scl;
	logic sda;
	assign scl = !((m_scl_oe && !m_scl_out) || (s_scl_oe && !s_scl_out));
	assign sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));
	modport host (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
		input scl, sda, interrupt_out_n);
	modport dev (output s_scl_out, s_scl_oe, s_sda_out, s_sda_oe, interrupt_out_n,
		input scl, sda);
endinterface

// ==== design/tsi2c_host.sv ====
// Two-wire master that software drives byte by byte.
// Assumes the device end on the same interface; SCL is made here by a divider.
`timescale 1ns/100ps
module tsi2c_host (
	input wire logic i_clk, // System clock
	input wire logic i_nrst, // Async reset, active low
	tsi2c_if.host link, // Link to the device
	input wire logic [1:0] i_addr, // Register address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata // Read data, cycle after i_rd
);
	import tsi2c_pkg::*;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} tsi2c_hstate_t;
	tsi2c_hstate_t st;
	logic [1:0] phase;
	logic [7:0] cnt;
	logic [3:0] bitn;
	logic [7:0] tx;
	logic [7:0] rx;
	logic do_xfer, do_stop, rd_mode, nack_mode, got_nack;
	logic scl_low, sda_low, next_scl_low, next_sda_low;
	logic scl_m, scl_q, sda_m, sda_q, irq_m, irq_q;
	// ==========================================
	// Pin synchronisers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			{scl_m, scl_q, sda_m, sda_q, irq_m, irq_q} <= 6'h3f;
		end else begin
			{scl_m, scl_q} <= {link.scl, scl_m};
			{sda_m, sda_q} <= {link.sda, sda_m};
			{irq_m, irq_q} <= {link.interrupt_out_n, irq_m};
		end
	end
	// ==========================================
	// Phase stepping; the release phase also waits out device stretching
	wire cnt_end = (cnt == QTR_CYC - 8'h01);
	wire step = (st != H_IDLE) && cnt_end && (phase != 2'h1 || scl_q);
	wire last_ph = step && (phase == 2'h3);
	wire ctrl_go = i_wr && (i_addr == HREG_CTRL) && (st == H_IDLE);
	wire tx_bit = (bitn == 4'h8) ? 1'b0 : ~tx[3'(4'h7 - bitn)];
	wire ack_bit = rd_mode ? ~nack_mode : 1'b0;
	wire bit_val = rd_mode ? ((bitn == 4'h8) & ack_bit) : tx_bit;
	always_comb begin
		next_scl_low = scl_low;
		next_sda_low = sda_low;
		case (st)
			H_IDLE: begin
				next_scl_low = scl_low;
			end
			H_START: begin
				next_scl_low = (phase == 2'h0) || (phase == 2'h3);
				next_sda_low = phase[1];
			end
			H_BITS: begin
				next_scl_low = (phase == 2'h0) || (phase == 2'h3);
				next_sda_low = bit_val;
			end
			H_STOP: begin
				next_scl_low = (phase == 2'h0);
				next_sda_low = !phase[1];
			end
			default: begin
				next_scl_low = 1'b0;
			end
		endcase
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			cnt <= 8'h00;
		end else begin
			scl_low <= next_scl_low;
			sda_low <= next_sda_low;
			cnt <= (step || st == H_IDLE) ? 8'h00 : (cnt_end ? cnt : cnt + 8'h01);
		end
	end
	// ==========================================
	// Sequencer: optional start, optional byte, optional stop
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= H_IDLE;
			phase <= 2'h0;
			bitn <= 4'h0;
			{do_xfer, do_stop, rd_mode, nack_mode, got_nack} <= 5'h00;
			rx <= 8'h00;
		end else if (ctrl_go) begin
			{do_xfer, do_stop} <= {i_wdata[HC_XFER], i_wdata[HC_STOP]};
			{rd_mode, nack_mode} <= {i_wdata[HC_READ], i_wdata[HC_NACK]};
			phase <= 2'h0;
			bitn <= 4'h0;
			if (i_wdata[HC_START]) begin
				st <= H_START;
			end else if (i_wdata[HC_XFER]) begin
				st <= H_BITS;
			end else if (i_wdata[HC_STOP]) begin
				st <= H_STOP;
			end
		end else if (step) begin
			phase <= phase + 2'h1;
			if (st == H_BITS && phase == 2'h2) begin
				if (bitn == 4'h8) begin
					got_nack <= sda_q;
				end else begin
					rx <= {rx[6:0], sda_q};
				end
			end
			if (last_ph) begin
				case (st)
					H_START: begin
						st <= do_xfer ? H_BITS : (do_stop ? H_STOP : H_IDLE);
					end
					H_BITS: begin
						bitn <= bitn + 4'h1;
						if (bitn == 4'h8) begin
							st <= do_stop ? H_STOP : H_IDLE;
						end
					end
					default: begin
						st <= H_IDLE;
					end
				endcase
			end
		end
	end
	// ==========================================
	// Software registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx <= 8'h00;
			o_rdata <= 8'h00;
		end else begin
			if (i_wr && i_addr == HREG_TX) begin
				tx <= i_wdata;
			end
			if (i_rd) begin
				case (i_addr)
					HREG_TX: o_rdata <= tx;
					HREG_RX: o_rdata <= rx;
					HREG_STAT: o_rdata <= {5'h00, ~irq_q, got_nack, st != H_IDLE};
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end
	assign link.m_scl_out = 1'b0;
	assign link.m_sda_out = 1'b0;
	assign link.m_scl_oe = scl_low;
	assign link.m_sda_oe = sda_low;
endmodule // tsi2c_host

// ==== design/tsi2c_dev.sv ====
// Slave end of the touch controller serial link: register access,
// host commands and compact channel reads from the last conversion.
// Assumes the conversion engine drives the i_conv_* inputs on i_clk.
//
// Notes on behaviour
// - Write: address, 000+pointer byte, data bytes acked
// - Pointer advances after each written data byte
// - Stretch after command byte while sampling busy (this code does not stretch after a 010 register-read command byte)
// - Register read: 010+pointer, restart, read address
// - Register read streams until master nacks, stop
// - Never stretch during register read transfers
// - After stop, read transfers become channel reads
// - Host command: one byte, top bit, seven-bit code
// - Channel read streams while master acknowledges
// - Master nack in channel read releases interrupt
// - Master stops before next conversion completes
// - Channel data is latest conversion snapshot
// - Enabled channels sent X, Y, Z1, Z2, AUX
// - Channel read stretches after read address
// - Word: zero, 3-bit tag, 12-bit result
// - Unconverted channel reads return all ones
// - Conversion without pen gives all ones words
// - Five-bit register map with soft reset
// - Hold SCL low while conversion in progress
// - Address low bit follows address select pin
// - Status read clears pen flag and interrupt
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module tsi2c_dev (
	input wire logic i_clk, // System clock
	input wire logic i_nrst, // Async reset, active low
	tsi2c_if.dev link, // Link to the host
	input wire logic i_address_select_pin, // Address low bit strap pin
	input wire logic i_conv_busy, // Conversion or processing running
	input wire logic i_conv_done, // Pulse: conversion sequence finished
	input wire logic i_conv_pen, // Pen seen during finished sequence
	input wire logic [tsi2c_pkg::N_CHANNEL_TAG-1:0] i_conv_valid, // Channels converted
	input wire logic [tsi2c_pkg::N_CHANNEL_TAG-1:0][11:0] i_conv_data, // Results
	input wire logic i_pen_event, // Pulse: pen detected
	output logic [7:0] o_control_zero, // Control register 0
	output logic [7:0] o_control_one, // Control register 1
	output logic [7:0] o_control_two, // Control register 2
	output logic [7:0] o_channel_enable_mask, // Channel mask
	output logic o_soft_reset, // Pulse: soft reset written
	output logic o_cmd_valid, // Pulse: host command received
	output logic [6:0] o_cmd_code // Last host command code
);
	import tsi2c_pkg::*;
	typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_RXACK} tsi2c_dstate_t;
	tsi2c_dstate_t st;
	logic scl_m, scl_q, scl_d, sda_m, sda_q, sda_d, asel_m, asel_q;
	logic [7:0] shreg, txsh;
	logic [3:0] bitn;
	logic got, first, is_read, reg_rd, wmode, cmd_pend, stretch, sda_low;
	logic [1:0] nbytes;
	logic [4:0] register_pointer;
	logic [2:0] ch;
	logic hi, pen_touch_flag, irq_pend;
	tsi2c_word_t snap [N_CHANNEL_TAG];
	logic [7:0] stat_val, reg_rdata, tx_byte;
	tsi2c_word_t word;

	function automatic logic [2:0] next_ch(input logic [2:0] from, input logic [7:0] m);
		logic [2:0] r;
		r = CH_NONE;
		for (int i = N_CHANNEL_TAG - 1; i >= 0; i--) begin
			if (3'(i) >= from && m[7 - i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// ==========================================
	// Pin synchronisers and bus conditions
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			{scl_m, scl_q, scl_d, sda_m, sda_q, sda_d} <= 6'h3f;
			{asel_m, asel_q} <= 2'h0;
		end else begin
			{scl_m, scl_q, scl_d} <= {link.scl, scl_m, scl_q};
			{sda_m, sda_q, sda_d} <= {link.sda, sda_m, sda_q};
			{asel_m, asel_q} <= {i_address_select_pin, asel_m};
		end
	end
	wire rise = scl_q && !scl_d;
	wire fall = !scl_q && scl_d;
	wire start_c = scl_q && scl_d && sda_d && !sda_q;
	wire stop_c = scl_q && scl_d && !sda_d && sda_q;
	wire [6:0] my_addr = {DEV_ADDR_HI, asel_q};
	wire addr_hit = (shreg[7:1] == my_addr);

	// ==========================================
	// Byte events
	wire byte_fall = (st == D_RX) && fall && got;
	wire data_fall = byte_fall && !first;
	wire cmd_byte = data_fall && (nbytes == 2'h0);
	wire wr_pulse = data_fall && (nbytes != 2'h0) && wmode;
	wire load_fall = (st == D_ACK) && fall && is_read;
	wire stat_rd = load_fall && reg_rd && (register_pointer == REG_STAT);
	wire acked = (st == D_RXACK) && rise && !sda_q;
	wire channel_tag_nack = (st == D_RXACK) && rise && sda_q && !reg_rd;
	wire addr_rd = byte_fall && first && addr_hit && shreg[0];
	// Only the command byte and a channel-read address may be stretched;
	// a register read is never held so its timing is fixed.
	// The 010 pointer byte opens a register read, so it is never held either.
	wire want_stretch = i_conv_busy &&
		((addr_rd && !reg_rd) || (cmd_byte && shreg[7:5] != CMD_READ));

	// ==========================================
	// Transfer sequencer
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= D_IDLE;
			{got, first, is_read, reg_rd, wmode, cmd_pend, sda_low} <= 7'h00;
			bitn <= 4'h0;
			nbytes <= 2'h0;
			shreg <= 8'h00;
			txsh <= 8'h00;
		end else if (start_c) begin
			st <= D_RX;
			{got, first, sda_low} <= 3'b010;
			bitn <= 4'h0;
			nbytes <= 2'h0;
		end else if (stop_c) begin
			st <= D_IDLE;
			sda_low <= 1'b0;
			reg_rd <= 1'b0;
			wmode <= 1'b0;
			cmd_pend <= 1'b0;
		end else begin
			case (st)
				D_RX: begin
					if (rise) begin
						shreg <= {shreg[6:0], sda_q};
						bitn <= bitn + 4'h1;
						got <= (bitn == 4'h7);
					end else if (byte_fall) begin
						got <= 1'b0;
						bitn <= 4'h0;
						first <= 1'b0;
						if (first && !addr_hit) begin
							st <= D_IDLE;
						end else begin
							st <= D_ACK;
							sda_low <= 1'b1;
						end
						if (first) begin
							is_read <= shreg[0];
						end
						if (!first && nbytes != 2'h3) begin
							nbytes <= nbytes + 2'h1;
						end
						if (cmd_byte) begin
							wmode <= (shreg[7:5] == CMD_WRITE);
							reg_rd <= (shreg[7:5] == CMD_READ);
							cmd_pend <= shreg[CMD_HOST_BIT];
						end
					end
				end
				D_ACK: begin
					if (fall) begin
						if (is_read) begin
							st <= D_TX;
							sda_low <= ~tx_byte[7];
							txsh <= {tx_byte[6:0], 1'b0};
							bitn <= 4'h1;
						end else begin
							st <= D_RX;
							sda_low <= 1'b0;
						end
					end
				end
				D_TX: begin
					if (fall) begin
						if (bitn == 4'h8) begin
							st <= D_RXACK;
							sda_low <= 1'b0;
						end else begin
							sda_low <= ~txsh[7];
							txsh <= {txsh[6:0], 1'b0};
							bitn <= bitn + 4'h1;
						end
					end
				end
				D_RXACK: begin
					if (rise) begin
						st <= sda_q ? D_IDLE : D_ACK;
					end
				end
				default: begin
					st <= D_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Clock stretch: held until the conversion engine goes idle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stretch <= 1'b0;
		end else begin
			stretch <= (stretch || want_stretch) && i_conv_busy;
		end
	end

	// ==========================================
	// Pointer and channel walk
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			register_pointer <= REG_CTRL0;
			ch <= CH_NONE;
			hi <= 1'b1;
		end else begin
			if (cmd_byte) begin
				register_pointer <= shreg[4:0];
			end else if (wr_pulse || (acked && reg_rd)) begin
				register_pointer <= register_pointer + 5'h01;
			end
			if (addr_rd) begin
				ch <= next_ch(3'h0, o_channel_enable_mask);
				hi <= 1'b1;
			end else if (acked && !reg_rd) begin
				hi <= !hi;
				if (!hi && ch != CH_NONE) begin
					ch <= next_ch(ch + 3'h1, o_channel_enable_mask);
				end
			end
		end
	end

	// ==========================================
	// Conversion snapshot; a result without pen or unconverted reads invalid
	for (genvar g = 0; g < N_CHANNEL_TAG; g++) begin : g_snap
		always_ff @(posedge i_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				snap[g] <= INVALID_WORD;
			end else if (i_conv_done) begin
				snap[g] <= (i_conv_valid[g] && i_conv_pen) ?
					{1'b0, 3'(g), i_conv_data[g]} : INVALID_WORD;
			end
		end
	end
	assign word = (ch == CH_NONE) ? INVALID_WORD : snap[ch];

	// ==========================================
	// Registers
	wire wr_ctrl0 = wr_pulse && register_pointer == REG_CTRL0;
	wire wr_ctrl1 = wr_pulse && register_pointer == REG_CTRL1;
	wire wr_ctrl2 = wr_pulse && register_pointer == REG_CTRL2;
	wire wr_mask = wr_pulse && register_pointer == REG_MASK;
	wire wr_srst = wr_pulse && register_pointer == REG_SRST;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_control_zero <= RST_CTRL0;
			o_control_one <= RST_CTRL1;
			o_control_two <= RST_CTRL2;
			o_channel_enable_mask <= RST_MASK;
		end else if (wr_srst) begin
			o_control_zero <= RST_CTRL0;
			o_control_one <= RST_CTRL1;
			o_control_two <= RST_CTRL2;
			o_channel_enable_mask <= RST_MASK;
		end else begin
			// Status and unlisted offsets fall through untouched
			if (wr_ctrl0) o_control_zero <= shreg;
			if (wr_ctrl1) o_control_one <= shreg;
			if (wr_ctrl2) o_control_two <= shreg;
			if (wr_mask) o_channel_enable_mask <= shreg;
		end
	end
	always_comb begin
		stat_val = 8'h00;
		stat_val[STAT_PEN_BIT] = pen_touch_flag;
		stat_val[STAT_PEND_BIT] = irq_pend;
	end
	assign reg_rdata = (register_pointer == REG_CTRL0) ? o_control_zero :
		(register_pointer == REG_CTRL1) ? o_control_one :
		(register_pointer == REG_CTRL2) ? o_control_two :
		(register_pointer == REG_MASK) ? o_channel_enable_mask :
		(register_pointer == REG_STAT) ? stat_val : 8'h00;
	assign tx_byte = reg_rd ? reg_rdata : (hi ? word[15:8] : word[7:0]);

	// ==========================================
	// Pen flag and interrupt; a new event wins over a clear in the same cycle
	wire conv_irq = i_conv_done && (i_conv_pen || !o_control_one[CTRL1_CONDIRQ_BIT]);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pen_touch_flag <= 1'b0;
			irq_pend <= 1'b0;
			o_soft_reset <= 1'b0;
			o_cmd_valid <= 1'b0;
			o_cmd_code <= 7'h00;
		end else begin
			pen_touch_flag <= i_pen_event || (pen_touch_flag && !stat_rd);
			irq_pend <= i_pen_event || conv_irq ||
				(irq_pend && !stat_rd && !channel_tag_nack);
			o_soft_reset <= wr_srst;
			o_cmd_valid <= stop_c && cmd_pend && (nbytes == 2'h1);
			if (cmd_byte && shreg[CMD_HOST_BIT]) begin
				o_cmd_code <= shreg[6:0];
			end
		end
	end

	assign link.s_scl_out = 1'b0;
	assign link.s_sda_out = 1'b0;
	assign link.s_scl_oe = stretch;
	assign link.s_sda_oe = sda_low;
	assign link.interrupt_out_n = ~irq_pend;
endmodule // tsi2c_dev

// ==== tb/tsi2c_props.sv ====
// Wire-level checks on the link joining the two ends.
// Assumes the resolved wire levels and device enables of one interface instance.
`timescale 1ns/100ps
module tsi2c_props (
	input wire logic i_clk, // System clock
	input wire logic i_nrst, // Async reset, active low
	input wire logic s_scl_oe, // Device clock stretch
	input wire logic s_sda_oe, // Device pulls data low
	input wire logic interrupt_out_n, // Interrupt line, active low
	input wire logic scl, // Resolved clock wire
	input wire logic sda // Resolved data wire
);
	// ==========================================
	// Frame tracking from the wires alone
	logic scl_q;
	logic sda_q;
	logic in_xfer;
	wire start_seen = scl && scl_q && sda_q && !sda;
	wire stop_seen = scl && scl_q && !sda_q && sda;
	wire next_in_xfer = start_seen ? 1'b1 : (stop_seen ? 1'b0 : in_xfer);
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_xfer <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			in_xfer <= next_in_xfer;
		end
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	property p_sda_chg_low;
		$changed(s_sda_oe) |-> !scl;
	endproperty
	a_sda_chg_low: assert property (p_sda_chg_low)
		else $error("device data moved while clock high");
	property p_stretch_low;
		$rose(s_scl_oe) |-> !scl;
	endproperty
	a_stretch_low: assert property (p_stretch_low)
		else $error("stretch began while clock high");
	property p_start_clk;
		scl && $past(scl) && $fell(sda) |-> ##[1:300] !scl;
	endproperty
	a_start_clk: assert property (p_start_clk)
		else $error("no clock after start");
	property p_scl_hi;
		$rose(scl) |-> scl[*8];
	endproperty
	a_scl_hi: assert property (p_scl_hi)
		else $error("clock high phase too short");
	property p_scl_lo;
		$fell(scl) |-> !scl[*8];
	endproperty
	a_scl_lo: assert property (p_scl_lo)
		else $error("clock low phase too short");
	property p_irq_xfer;
		$rose(interrupt_out_n) |-> in_xfer;
	endproperty
	a_irq_xfer: assert property (p_irq_xfer)
		else $error("interrupt released outside a transfer");
	property p_idle_sda;
		!in_xfer |-> !s_sda_oe;
	endproperty
	a_idle_sda: assert property (p_idle_sda)
		else $error("device drives data on idle bus");
	property p_idle_scl;
		!in_xfer |-> !s_scl_oe;
	endproperty
	a_idle_scl: assert property (p_idle_scl)
		else $error("device stretches idle bus");
endmodule // tsi2c_props

// ==== tb/tsi2c_tb.sv ====
// Self-checking bench: host end drives the device end over one link.
// Assumes the package quarter period as shipped; the run is some 81k cycles.
`timescale 1ns/100ps
module tsi2c_tb;
	import tsi2c_pkg::*;
	// ==========================================
	// Signals and ends
	localparam logic [4:0] K_ST = 5'h01;
	localparam logic [4:0] K_X = 5'h02;
	localparam logic [4:0] K_P = 5'h04;
	localparam logic [4:0] K_R = 5'h08;
	localparam logic [4:0] K_N = 5'h10;
	localparam logic [7:0] AW = {DEV_ADDR_HI, 2'b00};
	localparam logic [7:0] AR = {DEV_ADDR_HI, 2'b01};
	localparam logic [7:0] CH_EXP [8] = '{8'h01, 8'h23, 8'h14, 8'h56, 8'h2a, 8'hbc, 8'hff, 8'hff};
	logic i_clk, i_nrst, i_wr, i_rd, pin, busy, done, pen, pen_ev, seen, nk, cmdv, srst;
	logic [1:0] i_addr;
	logic [7:0] i_wdata, o_rdata, rx, ctl0, ctl1, ctl2, msk;
	logic [6:0] cmdc;
	logic [4:0] cval;
	logic [N_CHANNEL_TAG-1:0][11:0] cdat;
	int err_count, checks, ncmd, nsr;
	tsi2c_if link();
	tsi2c_host u_tsi2c_host (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
	tsi2c_dev u_tsi2c_dev (.i_clk(i_clk), .i_nrst(i_nrst), .link(link),
		.i_address_select_pin(pin), .i_conv_busy(busy), .i_conv_done(done), .i_conv_pen(pen),
		.i_conv_valid(cval), .i_conv_data(cdat), .i_pen_event(pen_ev), .o_control_zero(ctl0),
		.o_control_one(ctl1), .o_control_two(ctl2), .o_channel_enable_mask(msk),
		.o_soft_reset(srst), .o_cmd_valid(cmdv), .o_cmd_code(cmdc));
	tsi2c_props u_tsi2c_props (.i_clk(i_clk), .i_nrst(i_nrst), .s_scl_oe(link.s_scl_oe),
		.s_sda_oe(link.s_sda_oe), .interrupt_out_n(link.interrupt_out_n), .scl(link.scl),
		.sda(link.sda));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (link.s_scl_oe) seen <= 1'b1;
		if (cmdv) ncmd <= ncmd + 1;
		if (srst) nsr <= nsr + 1;
	end
	// ==========================================
	// Software port and byte operations
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rx = o_rdata;
	endtask
	// Bounded poll: a wedged link shows as one failed busy check
	task op(input logic [7:0] tx, input logic [4:0] c);
		int n;
		wr(HREG_TX, tx);
		wr(HREG_CTRL, {3'h0, c});
		n = 0;
		do begin
			rd(HREG_STAT);
			n++;
		end while (rx[HS_BUSY] !== 1'b0 && n < 30000);
		chk({7'h0, rx[HS_BUSY]}, 8'h00);
		nk = rx[HS_NACK];
		rd(HREG_RX);
	endtask
	task xb(input logic [7:0] tx, input logic [4:0] c, input logic expn);
		op(tx, c);
		chk({7'h0, nk}, {7'h0, expn});
	endtask
	task conv(input logic [4:0] v, input logic p);
		@(posedge i_clk);
		cval <= v;
		pen <= p;
		done <= 1'b1;
		@(posedge i_clk);
		done <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
	// ==========================================
	// Scenarios
	task t_write;
		xb(AW, K_ST | K_X, 1'b0);
		xb({CMD_WRITE, REG_CTRL0}, K_X, 1'b0);
		for (int i = 0; i < 5; i++) begin
			xb((i == 4) ? 8'hf8 : 8'ha1 + 8'(i), K_X | ((i == 4) ? K_P : 5'h00), 1'b0);
		end
		chk(ctl0, 8'ha1);
		chk(ctl1, 8'ha2);
		chk(ctl2, 8'ha3);
		chk(msk, 8'hf8);
		$display("register write test done");
	endtask
	task t_regrd;
		@(posedge i_clk);
		pen_ev <= 1'b1;
		@(posedge i_clk);
		pen_ev <= 1'b0;
		busy <= 1'b1;
		seen <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk({7'h0, link.interrupt_out_n}, 8'h00);
		xb(AW, K_ST | K_X, 1'b0);
		xb({CMD_READ, REG_CTRL0}, K_X, 1'b0);
		xb(AR, K_ST | K_X, 1'b0);
		for (int i = 0; i < 6; i++) begin
			op(8'hff, K_X | K_R | ((i == 5) ? K_N | K_P : 5'h00));
			if (i < 3) chk(rx, 8'ha1 + 8'(i));
			if (i == 4) chk(rx, 8'hf8);
		end
		chk({7'h0, rx[STAT_PEN_BIT]}, 8'h01);
		chk({7'h0, link.interrupt_out_n}, 8'h01);
		chk({7'h0, seen}, 8'h00);
		@(posedge i_clk);
		busy <= 1'b0;
		$display("register read test done");
	endtask
	task t_channel_tag;
		cdat <= {12'h0, 12'h0, 12'habc, 12'h456, 12'h123};
		conv(5'b00111, 1'b1);
		chk({7'h0, link.interrupt_out_n}, 8'h00);
		busy <= 1'b1;
		seen <= 1'b0;
		fork
			begin
				repeat (3000) @(posedge i_clk);
				busy <= 1'b0;
			end
		join_none
		xb(AR, K_ST | K_X, 1'b0);
		for (int i = 0; i < 8; i++) begin
			op(8'hff, K_X | K_R | ((i == 7) ? K_N | K_P : 5'h00));
			chk(rx, CH_EXP[i]);
		end
		chk({7'h0, seen}, 8'h01);
		chk({7'h0, link.interrupt_out_n}, 8'h01);
		$display("channel read test done");
	endtask
	task t_nopen;
		conv(5'b11111, 1'b0);
		xb(AR, K_ST | K_X, 1'b0);
		for (int i = 0; i < 2; i++) begin
			op(8'hff, K_X | K_R | ((i == 1) ? K_N | K_P : 5'h00));
			chk(rx, 8'hff);
		end
		$display("pen-less read test done");
	endtask
	task t_cmd;
		xb(AW, K_ST | K_X, 1'b0);
		@(posedge i_clk);
		busy <= 1'b1;
		seen <= 1'b0;
		// Released well after the command byte, so the stretch must show
		fork
			begin
				repeat (3000) @(posedge i_clk);
				busy <= 1'b0;
			end
		join_none
		xb(8'haa, K_X | K_P, 1'b0);
		repeat (8) @(posedge i_clk);
		chk({7'h0, seen}, 8'h01);
		chk({1'b0, cmdc}, 8'h2a);
		chk(8'(ncmd), 8'h01);
		$display("host command test done");
	endtask
	task t_addr;
		xb(AW | 8'h02, K_ST | K_X | K_P, 1'b1);
		@(posedge i_clk);
		pin <= 1'b1;
		repeat (4) @(posedge i_clk);
		xb(AW | 8'h02, K_ST | K_X, 1'b0);
		xb({CMD_WRITE, REG_SRST}, K_X, 1'b0);
		xb(8'h00, K_X | K_P, 1'b0);
		repeat (4) @(posedge i_clk);
		chk(ctl0, RST_CTRL0);
		chk(ctl1, RST_CTRL1);
		chk(ctl2, RST_CTRL2);
		chk(msk, RST_MASK);
		chk(8'(nsr), 8'h01);
		$display("address select test done");
	endtask
	task close_out;
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		{i_nrst, i_wr, i_rd, pin, busy, done, pen, pen_ev, seen} = '0;
		{i_addr, i_wdata, cval, cdat} = '0;
		{err_count, checks, ncmd, nsr} = '0;
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_write;
		t_regrd;
		t_channel_tag;
		t_nopen;
		t_cmd;
		t_addr;
		close_out;
	end
	initial begin
		// About 95k cycles: some 14k above the expected run
		#950000;
		err_count++;
		close_out;
	end
endmodule // tsi2c_tb
